/* hw/selwake_defs.svh */
// Constant definitions for the selective-wake payload and FD configuration bank.
`ifndef SELWAKE_DEFS_SVH
`define SELWAKE_DEFS_SVH

// ----------------------------------------------------------------------------
// Register addresses (7-bit serial address space).
// ----------------------------------------------------------------------------
`define ADDR_PAYLOAD_B3   7'h30
`define ADDR_PAYLOAD_B2   7'h31
`define ADDR_PAYLOAD_B1   7'h32
`define ADDR_PAYLOAD_B0   7'h33
`define ADDR_FD_CFG       7'h34
`define ADDR_WAKE_OPT     7'h39

// ----------------------------------------------------------------------------
// Reset values and field layout.
// ----------------------------------------------------------------------------
`define REG_RESET         8'h00
`define FD_CFG_RESET      6'h00
`define FD_ERRDIS_BIT     5
`define FD_BYPASS_BIT     4
`define FD_FILT_MSB       3
`define FD_FILT_LSB       1
`define FD_EN_BIT         0
`define FD_STORED_MSB     5
`define OPT_RXSEL_BIT     7

// ----------------------------------------------------------------------------
// Dominant filter timing and serial frame layout.
// ----------------------------------------------------------------------------
`define FILT_STEP_NS      10'h032
`define FILT_LONG_NS      10'h2bc
`define FILT_LONG_CODE    3'h7
`define FRAME_HALF_LAST   3'h7

`endif

/* hw/selwake_pkg.sv */
// Types shared by the selective-wake register bank and its serial engine.
package selwake_pkg;

  // Serial frame phases, Gray coded along idle, header, data, done.
  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_HEADER = 2'b01,
    PH_DATA   = 2'b11,
    PH_DONE   = 2'b10
  } frame_phase_t;

  // Complete state of the serial frame engine.
  typedef struct packed {
    logic         cs_meta;
    logic         cs_sync;
    logic         sclk_meta;
    logic         sclk_sync;
    logic         sclk_prev;
    logic         mosi_meta;
    logic         mosi_sync;
    frame_phase_t phase;
    logic [2:0]   cnt;
    logic [15:0]  shin;
    logic [7:0]   shout;
    logic [6:0]   addr;
    logic         wr;
    logic         fetch;
    logic [7:0]   wdata;
    logic         wr_stb;
  } spi_state_t;

  // Complete state of the register bank.
  typedef struct packed {
    logic [7:0] pay3;
    logic [7:0] pay2;
    logic [7:0] pay1;
    logic [7:0] pay0;
    logic [5:0] fd_cfg;
    logic       rx_sel;
  } bank_state_t;

endpackage

/* hw/reg_access_if.sv */
// Interface carrying register accesses from the serial engine to the bank.
`timescale 1ns/10ps
interface reg_access_if;
  logic [6:0] addr;
  logic       wr_stb;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport engine (output addr, output wr_stb, output wdata, input rdata);
  modport bank   (input addr, input wr_stb, input wdata, output rdata);
endinterface

/* hw/spi_frame_engine.sv */
// Serial peripheral slave that turns 16-bit frames into register accesses.
`timescale 1ns/10ps
`include "selwake_defs.svh"
module spi_frame_engine
  import selwake_pkg::*;
(
  input  wire logic    mclk_i,
  input  wire logic    rst_i,
  input  wire logic    sclk_i,
  input  wire logic    csn_i,
  input  wire logic    mosi_i,
  output logic         miso_o,
  output logic         miso_oe_o,
  reg_access_if.engine acc
);

  spi_state_t st_ff;
  spi_state_t nxt_st;
  logic       rise;
  logic       fall;
  logic [15:0] shifted;

  // Select idles high, so its synchroniser resets to the deselected level.
  // A zero reset would show a selected bus for two cycles after release.
  localparam spi_state_t SPI_RESET = '{cs_meta: 1'b1, cs_sync: 1'b1,
                                       phase: PH_IDLE, default: '0};

  // ----------------------------------------------------------------------------
  // Frame sequencing. Pins pass two flops; edge detect also reads a third sclk flop.
  // ----------------------------------------------------------------------------
  // Bits arrive LSB first: 7 address bits, write flag, then 8 data bits.
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.cs_meta   = csn_i;
    nxt_st.cs_sync   = st_ff.cs_meta;
    nxt_st.sclk_meta = sclk_i;
    nxt_st.sclk_sync = st_ff.sclk_meta;
    nxt_st.sclk_prev = st_ff.sclk_sync;
    nxt_st.mosi_meta = mosi_i;
    nxt_st.mosi_sync = st_ff.mosi_meta;
    nxt_st.wr_stb    = 1'b0;
    rise    = st_ff.sclk_sync & ~st_ff.sclk_prev;
    fall    = ~st_ff.sclk_sync & st_ff.sclk_prev;
    shifted = {st_ff.mosi_sync, st_ff.shin[15:1]};
    if (st_ff.cs_sync) begin
      nxt_st.phase = PH_IDLE;
      nxt_st.cnt   = 3'h0;
      nxt_st.shout = 8'h00;
      nxt_st.fetch = 1'b0;
    end else begin
      case (st_ff.phase)
        PH_IDLE: begin
          nxt_st.phase = PH_HEADER;
          nxt_st.cnt   = 3'h0;
        end
        PH_HEADER: begin
          if (rise) begin
            nxt_st.shin = shifted;
            nxt_st.cnt  = st_ff.cnt + 3'h1;
            if (st_ff.cnt == `FRAME_HALF_LAST) begin
              nxt_st.addr  = shifted[14:8];
              nxt_st.wr    = shifted[15];
              nxt_st.fetch = 1'b1;
              nxt_st.phase = PH_DATA;
            end
          end
        end
        PH_DATA: begin
          // Read data is loaded once, the cycle after the address is known.
          if (st_ff.fetch) begin
            nxt_st.shout = acc.rdata;
            nxt_st.fetch = 1'b0;
          end else if (fall && st_ff.cnt != 3'h0) begin
            nxt_st.shout = {1'b0, st_ff.shout[7:1]};
          end
          if (rise) begin
            nxt_st.shin = shifted;
            nxt_st.cnt  = st_ff.cnt + 3'h1;
            if (st_ff.cnt == `FRAME_HALF_LAST) begin
              nxt_st.wdata  = shifted[15:8];
              nxt_st.wr_stb = st_ff.wr;
              nxt_st.phase  = PH_DONE;
            end
          end
        end
        default: begin
          // Extra clocks past 16 bits are ignored until select goes high.
          nxt_st.phase = PH_DONE;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_ff <= SPI_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from flops.
  assign acc.addr   = st_ff.addr;
  assign acc.wr_stb = st_ff.wr_stb;
  assign acc.wdata  = st_ff.wdata;
  assign miso_o     = st_ff.shout[0];
  assign miso_oe_o  = ~st_ff.cs_sync;

endmodule

/* hw/selwake_payload_fd_config.sv */
// Register bank for selective-wake payload bytes and FD tolerant settings.
//
// Functional notes
// - Four read/write payload bytes, byte 3 to byte 0, sit at 0x30..0x33.
// - Each payload byte holds its reference value in bits 7:0, LSB bit 0.
// - Reset or soft reset clears payload and FD config; restart keeps them.
// - The 8-bit FD configuration register sits at address 0x34.
// - On restart FD bits 5:0 keep their values and bits 7:6 become zero.
// - FD configuration bits 7:6 always read as zero.
// - With the counter disable bit clear the frame error counter runs.
// - Counter disable suspends the error counter only while FD enable is set.
// - Bus silence timeout clears the counter disable bit; software may write it.
// - The bypass bit removes the analog filter from the receive path.
// - Filter code 0..6 gives 50 ns steps from 50 ns, code 7 gives 700 ns.
// - The dominant filter is outside the analog path and is never bypassed.
// - Bit 0 turns FD tolerant mode on when set and off when clear.
// - Options bit 7 picks the low-power receiver at 0, standard at 1.
`timescale 1ns/10ps
`include "selwake_defs.svh"
module selwake_payload_fd_config
  import selwake_pkg::*;
(
  input  wire logic  mclk_i,
  input  wire logic  rst_i,
  input  wire logic  soft_reset_i,
  input  wire logic  restart_i,
  input  wire logic  silence_timeout_i,
  input  wire logic  sclk_i,
  input  wire logic  csn_i,
  input  wire logic  mosi_i,
  output logic       miso_o,
  output logic       miso_oe_o,
  output logic [31:0] payload_o,
  output logic       fd_tolerant_en_o,
  output logic       error_counter_run_o,
  output logic       analog_filter_bypass_o,
  output logic [2:0] dominant_filter_time_o,
  output logic [9:0] dominant_filter_ns_o,
  output logic       wake_receiver_select_o
);

  bank_state_t st_ff;
  bank_state_t nxt_st;
  reg_access_if acc ();

  // ----------------------------------------------------------------------------
  // Serial front end.
  // ----------------------------------------------------------------------------
  spi_frame_engine u_engine (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .sclk_i    (sclk_i),
    .csn_i     (csn_i),
    .mosi_i    (mosi_i),
    .miso_o    (miso_o),
    .miso_oe_o (miso_oe_o),
    .acc       (acc)
  );

  // ----------------------------------------------------------------------------
  // Register update.
  // ----------------------------------------------------------------------------
  // A restart leaves every stored bit alone; reserved bits have no storage,
  // so they come back as zero for free.
  always_comb begin
    nxt_st = st_ff;
    if (soft_reset_i) begin
      nxt_st.pay3   = `REG_RESET;
      nxt_st.pay2   = `REG_RESET;
      nxt_st.pay1   = `REG_RESET;
      nxt_st.pay0   = `REG_RESET;
      nxt_st.fd_cfg = `FD_CFG_RESET;
      nxt_st.rx_sel = 1'b0;
    end else if (acc.wr_stb) begin
      if (acc.addr == `ADDR_PAYLOAD_B3) begin
        nxt_st.pay3 = acc.wdata;
      end else if (acc.addr == `ADDR_PAYLOAD_B2) begin
        nxt_st.pay2 = acc.wdata;
      end else if (acc.addr == `ADDR_PAYLOAD_B1) begin
        nxt_st.pay1 = acc.wdata;
      end else if (acc.addr == `ADDR_PAYLOAD_B0) begin
        nxt_st.pay0 = acc.wdata;
      end else if (acc.addr == `ADDR_FD_CFG) begin
        nxt_st.fd_cfg = acc.wdata[`FD_STORED_MSB:0];
      end else if (acc.addr == `ADDR_WAKE_OPT) begin
        nxt_st.rx_sel = acc.wdata[`OPT_RXSEL_BIT];
      end
    end
    // The timeout clear wins over a same-cycle software write of the bit,
    // so a late write cannot keep the counter suspended past silence.
    if (silence_timeout_i && !soft_reset_i) begin
      nxt_st.fd_cfg[`FD_ERRDIS_BIT] = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------------
  // Read decode. Unmapped addresses read as zero.
  // ----------------------------------------------------------------------------
  always_comb begin
    acc.rdata = 8'h00;
    if (acc.addr == `ADDR_PAYLOAD_B3) begin
      acc.rdata = st_ff.pay3;
    end else if (acc.addr == `ADDR_PAYLOAD_B2) begin
      acc.rdata = st_ff.pay2;
    end else if (acc.addr == `ADDR_PAYLOAD_B1) begin
      acc.rdata = st_ff.pay1;
    end else if (acc.addr == `ADDR_PAYLOAD_B0) begin
      acc.rdata = st_ff.pay0;
    end else if (acc.addr == `ADDR_FD_CFG) begin
      acc.rdata = {2'b00, st_ff.fd_cfg};
    end else if (acc.addr == `ADDR_WAKE_OPT) begin
      acc.rdata = {st_ff.rx_sel, 7'h00};
    end
  end

  // ----------------------------------------------------------------------------
  // Configuration outputs toward the receiver and frame detector.
  // ----------------------------------------------------------------------------
  assign payload_o = {st_ff.pay3, st_ff.pay2, st_ff.pay1, st_ff.pay0};
  assign fd_tolerant_en_o = st_ff.fd_cfg[`FD_EN_BIT];
  // The counter is only suspended when both bits are set.
  assign error_counter_run_o = ~(st_ff.fd_cfg[`FD_ERRDIS_BIT] &
                                 st_ff.fd_cfg[`FD_EN_BIT]);
  assign analog_filter_bypass_o = st_ff.fd_cfg[`FD_BYPASS_BIT];
  assign dominant_filter_time_o =
    st_ff.fd_cfg[`FD_FILT_MSB:`FD_FILT_LSB];
  // The dominant filter follows its code alone; bypass never enters here,
  // since it sits after the analog path.
  always_comb begin
    if (dominant_filter_time_o == `FILT_LONG_CODE) begin
      dominant_filter_ns_o = `FILT_LONG_NS;
    end else begin
      dominant_filter_ns_o = 10'((dominant_filter_time_o + 4'h1) * `FILT_STEP_NS);
    end
  end
  // Software must set this for FD tolerance above 1 Mbit/s.
  assign wake_receiver_select_o = st_ff.rx_sel;

  // ----------------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_payload_b3_write: assert property (
    acc.wr_stb && acc.addr == `ADDR_PAYLOAD_B3 && !soft_reset_i
    |=> payload_o[31:24] == $past(acc.wdata))
    else $error("payload byte 3 write not stored");
  a_payload_b0_order: assert property (
    acc.wr_stb && acc.addr == `ADDR_PAYLOAD_B0 && !soft_reset_i
    |=> payload_o[7:0] == $past(acc.wdata) &&
        $stable(payload_o[31:8]))
    else $error("payload byte 0 not in low bits");
  a_soft_reset_clear: assert property (
    soft_reset_i |=> payload_o == 32'h0000_0000 && !fd_tolerant_en_o &&
                     dominant_filter_time_o == 3'h0 && error_counter_run_o)
    else $error("soft reset left contents");
  a_restart_keeps: assert property (
    restart_i && !soft_reset_i && !acc.wr_stb && !silence_timeout_i
    |=> $stable(payload_o) && $stable(dominant_filter_time_o) &&
        $stable(analog_filter_bypass_o) && $stable(fd_tolerant_en_o))
    else $error("restart altered stored configuration");
  a_fd_write: assert property (
    acc.wr_stb && acc.addr == `ADDR_FD_CFG && !soft_reset_i &&
    !silence_timeout_i
    |=> dominant_filter_time_o == $past(acc.wdata[3:1]) &&
        fd_tolerant_en_o == $past(acc.wdata[0]) &&
        analog_filter_bypass_o == $past(acc.wdata[4]))
    else $error("FD configuration write not stored");
  a_reserved_zero: assert property (
    acc.addr == `ADDR_FD_CFG |-> acc.rdata[7:6] == 2'b00)
    else $error("reserved FD bits read nonzero");
  a_counter_gate: assert property (
    acc.wr_stb && acc.addr == `ADDR_FD_CFG && !soft_reset_i &&
    !silence_timeout_i
    |=> error_counter_run_o == !($past(acc.wdata[5]) && $past(acc.wdata[0])))
    else $error("error counter gating wrong");
  a_silence_clear: assert property (
    silence_timeout_i |=> error_counter_run_o &&
                          (acc.rdata[5] == 1'b0 ||
                           acc.addr != `ADDR_FD_CFG))
    else $error("silence timeout did not clear disable bit");
  a_filter_time: assert property (
    dominant_filter_time_o == 3'h7 |-> dominant_filter_ns_o == 10'd700)
    else $error("long filter time wrong");
  a_filter_unbypassed: assert property (
    $rose(analog_filter_bypass_o) && $stable(dominant_filter_time_o)
    |-> $stable(dominant_filter_ns_o) && dominant_filter_ns_o != 10'd0)
    else $error("bypass disturbed dominant filter");
  a_rx_select: assert property (
    acc.wr_stb && acc.addr == `ADDR_WAKE_OPT && !soft_reset_i
    |=> wake_receiver_select_o == $past(acc.wdata[7]))
    else $error("receiver select not stored");

  c_payload_write: cover property (
    acc.wr_stb && acc.addr == `ADDR_PAYLOAD_B2);
  c_fd_suspend: cover property (!error_counter_run_o);
  c_silence_clear: cover property (!error_counter_run_o ##1 silence_timeout_i);
  c_restart: cover property (restart_i && payload_o != 32'h0000_0000);

endmodule

/* bench/spi_host_model.sv */
// Serial host model that frames register reads and writes for the bank.
`timescale 1ns/10ps
module spi_host_model (
  input  wire logic mclk_i,
  input  wire logic miso_i,
  input  wire logic miso_oe_i,
  output logic      sclk_o,
  output logic      csn_o,
  output logic      mosi_o
);
  logic last_ff;
  logic line;

  initial begin
    sclk_o = 1'b0;
    csn_o  = 1'b1;
    mosi_o = 1'b0;
  end

  // A released data line shows the inverse of its last level, so a stale
  // bit is never mistaken for a driven one.
  always_ff @(posedge mclk_i) begin
    if (miso_oe_i) begin
      last_ff <= miso_i;
    end
  end
  assign line = miso_oe_i ? miso_i : ~last_ff;

  // One frame: seven address bits and the write flag, then eight data bits,
  // all least significant bit first; the clock halves last five cycles.
  task automatic xfer(input logic [6:0] addr, input logic wr,
                      input logic [7:0] wdata, output logic [7:0] rdata);
    logic [15:0] frame;
    frame = {wdata, wr, addr};
    rdata = 8'h00;
    @(posedge mclk_i);
    csn_o <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      mosi_o <= frame[i];
      sclk_o <= 1'b0;
      repeat (5) @(posedge mclk_i);
      if (i >= 8) begin
        rdata[i-8] = line;
      end
      sclk_o <= 1'b1;
      repeat (5) @(posedge mclk_i);
    end
    sclk_o <= 1'b0;
    repeat (8) @(posedge mclk_i);
    csn_o <= 1'b1;
    repeat (5) @(posedge mclk_i);
  endtask
endmodule

/* bench/testbench.sv */
// Self-checking bench for the selective-wake register bank.
`timescale 1ns/10ps
`include "selwake_defs.svh"
module testbench;
  logic       mclk_i;
  logic       rst_i;
  logic       soft_reset_i;
  logic       restart_i;
  logic       silence_timeout_i;
  logic       sclk;
  logic       csn;
  logic       mosi;
  logic       miso;
  logic       miso_oe;
  logic [31:0] payload;
  logic       fd_en;
  logic       err_run;
  logic       byp;
  logic [2:0] ftime;
  logic [9:0] fns;
  logic       rxsel;
  int         n_mismatch;
  int         checks;
  int         cyc;

  selwake_payload_fd_config u_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .soft_reset_i(soft_reset_i),
    .restart_i(restart_i), .silence_timeout_i(silence_timeout_i),
    .sclk_i(sclk), .csn_i(csn), .mosi_i(mosi), .miso_o(miso),
    .miso_oe_o(miso_oe), .payload_o(payload), .fd_tolerant_en_o(fd_en),
    .error_counter_run_o(err_run), .analog_filter_bypass_o(byp),
    .dominant_filter_time_o(ftime), .dominant_filter_ns_o(fns),
    .wake_receiver_select_o(rxsel)
  );

  spi_host_model u_host (
    .mclk_i(mclk_i), .miso_i(miso), .miso_oe_i(miso_oe),
    .sclk_o(sclk), .csn_o(csn), .mosi_o(mosi)
  );

  // ---------------------------------------------------------------------
  // Clock, timeout and shared tasks.
  // ---------------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  // About forty frames of roughly 180 cycles each fit well below this.
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    logic [7:0] d;
    u_host.xfer(addr, 1'b1, data, d);
  endtask

  task automatic rd(input logic [6:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    u_host.xfer(addr, 1'b0, 8'h00, d);
    check($sformatf("reg %h", addr), {24'h0, d}, {24'h0, exp});
  endtask

  // ---------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------
  initial begin
    logic [7:0] pat [4];
    logic [2:0] c;
    logic [9:0] ens;
    pat = '{8'h12, 8'h34, 8'hc8, 8'h07};
    rst_i = 1'b1;
    soft_reset_i = 1'b0;
    restart_i = 1'b0;
    silence_timeout_i = 1'b0;
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    // The data output must stay released through the first edges after reset.
    repeat (2) @(negedge mclk_i);
    check("oe", {31'h0, miso_oe}, 32'h0);
    repeat (5) @(posedge mclk_i);
    for (int a = 0; a < 5; a++) rd(7'h30 + a[6:0], 8'h00);
    check("run", {31'h0, err_run}, 32'h1);
    check("ns", {22'h0, fns}, 32'd50);
    // FD tolerance above 1 Mbit/s wants the standard receiver selected.
    wr(`ADDR_WAKE_OPT, 8'hff);
    rd(`ADDR_WAKE_OPT, 8'h80);
    check("rxsel", {31'h0, rxsel}, 32'h1);
    for (int a = 0; a < 4; a++) wr(7'h30 + a[6:0], pat[a]);
    for (int a = 0; a < 4; a++) rd(7'h30 + a[6:0], pat[a]);
    check("payload", payload, {pat[0], pat[1], pat[2], pat[3]});
    rd(7'h35, 8'h00);
    // Every filter code, with reserved bits written high each time.
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      ens = (c == 3'h7) ? 10'd700 : 10'd50 * (10'(c) + 10'd1);
      wr(`ADDR_FD_CFG, {3'b110, c[0], c, 1'b1});
      rd(`ADDR_FD_CFG, {3'b000, c[0], c, 1'b1});
      check("ftime", {29'h0, ftime}, {29'h0, c});
      check("ns", {22'h0, fns}, {22'h0, ens});
      check("bypass", {31'h0, byp}, {31'h0, c[0]});
      check("fd_en", {31'h0, fd_en}, 32'h1);
      check("run", {31'h0, err_run}, 32'h1);
    end
    wr(`ADDR_FD_CFG, 8'h20);
    check("fd_en", {31'h0, fd_en}, 32'h0);
    check("run", {31'h0, err_run}, 32'h1);
    wr(`ADDR_FD_CFG, 8'h21);
    check("run", {31'h0, err_run}, 32'h0);
    @(posedge mclk_i) silence_timeout_i <= 1'b1;
    @(posedge mclk_i) silence_timeout_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    check("run", {31'h0, err_run}, 32'h1);
    rd(`ADDR_FD_CFG, 8'h01);
    wr(`ADDR_FD_CFG, 8'h3f);
    @(posedge mclk_i) restart_i <= 1'b1;
    @(posedge mclk_i) restart_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rd(`ADDR_FD_CFG, 8'h3f);
    check("payload", payload, {pat[0], pat[1], pat[2], pat[3]});
    @(posedge mclk_i) soft_reset_i <= 1'b1;
    @(posedge mclk_i) soft_reset_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    check("payload", payload, 32'h0);
    rd(`ADDR_PAYLOAD_B3, 8'h00);
    rd(`ADDR_FD_CFG, 8'h00);
    check("rxsel", {31'h0, rxsel}, 32'h0);
    wr(`ADDR_WAKE_OPT, 8'h80);
    check("rxsel", {31'h0, rxsel}, 32'h1);
    wr(`ADDR_WAKE_OPT, 8'h7f);
    check("rxsel", {31'h0, rxsel}, 32'h0);
    results();
  end
endmodule
